// ### ralf_defs.svh
// Constants for the relay alarm flag logic: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RALF_DEFS_SVH
`define RALF_DEFS_SVH

// Register byte offsets
`define RALF_ADDR_CTRL      8'h00
`define RALF_ADDR_GOV_DLY   8'h04
`define RALF_ADDR_USER      8'h08
`define RALF_ADDR_STATUS    8'h0C
`define RALF_ADDR_LATCH     8'h10
`define RALF_ADDR_PDIR_ANG  8'h14
`define RALF_ADDR_GDIR_ANG  8'h18

// Control register fields
`define RALF_CTRL_PDIR_EN   0
`define RALF_CTRL_GDIR_EN   1
`define RALF_CTRL_SEAL_CLR  2

// Reset values
`define RALF_CTRL_RST       2'h3
`define RALF_GOV_DLY_RST    8'h02
`define RALF_ANG_RST        9'h000
`define RALF_RDATA_RST      32'h0000_0000

// Timing and geometry
`define RALF_CLK_HZ         25000000
`define RALF_TICK_S         1
`define RALF_QUAL_S         60
`define RALF_SECTOR_DEG     180
`define RALF_FULL_DEG       360

`endif

// ### ralf_far_model.sv
// Far-side model: measurement results and user logic fabric.
// Assumes the bench sets its fields between edges.
`timescale 1ns/1ns
module ralf_far_model (
  input  wire logic             clk_in,
  input  wire logic             off_in,
  output ralf_pkg::ralf_meas_t  meas_out = '0,
  output ralf_pkg::ralf_close_t close_out = '0,
  output logic                  set_out = 1'b0,
  output logic                  reset_out = 1'b0,
  output logic [15:0]           user_out = 16'h0000
);
  ralf_pkg::ralf_meas_t m   = '0;
  logic [2:0]           req = 3'h0;
  logic                 s   = 1'b0;
  logic                 r   = 1'b0;
  logic [15:0]          u   = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs move just after each rising edge
  always @(posedge clk_in) begin
    meas_out  <= m;
    close_out <= {req[2:1], req[0] & ~off_in};
    set_out   <= s;
    reset_out <= r;
    user_out  <= u;
  end
endmodule : ralf_far_model

// ### ralf_pkg.sv
// Types shared by the relay alarm flag logic.
// Assumes the measurement engine delivers results on the system clock.
package ralf_pkg;

  // Hot hold tag states
  typedef enum logic [1:0] {
    hht_on,
    hht_off,
    hht_tag
  } ralf_hht_state_t;

  // Comparator and angle results from the measurement engine
  typedef struct packed {
    logic [8:0] pos_angle;
    logic [8:0] neg_angle;
    logic [2:0] uv_below;
    logic       var_dmd_over;
    logic       watt1_over;
    logic       gnd_volt_over;
    logic       main_trip;
    logic [2:0] trip_phase;
    logic [2:0] below_dropout;
    logic       cold_load_run;
  } ralf_meas_t;

  // Close requests from the closing logic
  typedef struct packed {
    logic manual_local;
    logic manual_remote;
    logic autoreclose;
  } ralf_close_t;

endpackage : ralf_pkg

// ### ralf_qual_timer.sv
// Qualification timer counting one-second ticks while a condition holds.
// Assumes tick_in is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
module ralf_qual_timer #(
  parameter int CW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          tick_in,
  input  wire logic          cond_in,
  input  wire logic [CW-1:0] limit_in,
  output logic               flag_out
);

  logic [CW-1:0] count;

  generate
    if (CW < 1) begin : g_bad_width
      $error("ralf_qual_timer: CW must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Count ticks while the condition holds; drop all when it goes away
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count    <= '0;
      flag_out <= 1'b0;
    end else if (!cond_in) begin
      count    <= '0;
      flag_out <= 1'b0;
    end else if (tick_in && !flag_out) begin
      if ({1'b0, count} + {{CW{1'b0}}, 1'b1} >= {1'b0, limit_in}) begin
        flag_out <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : ralf_qual_timer

// ### ralf_top.sv
// Relay alarm flag logic: zone flags, alarms, trip flags, hot hold tag.
// Assumes measurement results and close requests arrive on clk_in and an
// Avalon-MM master with waitrequest reaches the registers.
//
// The register offsets and register access over Avalon-MM were decided locally.
`include "ralf_defs.svh"
`timescale 1ns/1ns

module ralf_top #(
  parameter int TICK_CYCLES = `RALF_CLK_HZ * `RALF_TICK_S,
  parameter int QUAL_TICKS  = `RALF_QUAL_S / `RALF_TICK_S,
  parameter int DLY_W       = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [7:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic [31:0]               avs_readdata_out,
  output logic                      avs_waitrequest_out,
  input  wire ralf_pkg::ralf_meas_t meas_in,
  input  wire ralf_pkg::ralf_close_t close_req_in,
  input  wire logic                 hold_tag_set_in,
  input  wire logic                 hold_tag_reset_in,
  input  wire logic [15:0]          user_logic_eq_in,
  output logic                      pos_seq_zone_flag_out,
  output logic                      neg_seq_zone_flag_out,
  output logic                      three_phase_undervolt_flag_out,
  output logic                      three_phase_undervolt_latched_out,
  output logic                      var_demand_flag_out,
  output logic                      trip_phase_a_flag_out,
  output logic                      trip_phase_b_flag_out,
  output logic                      trip_phase_c_flag_out,
  output logic                      trip_phase_a_latched_out,
  output logic                      trip_phase_b_latched_out,
  output logic                      trip_phase_c_latched_out,
  output logic                      cold_load_timing_flag_out,
  output logic                      pos_watt_alarm_one_out,
  output logic                      ground_overvolt_flag_out,
  output logic                      hold_tag_off_out,
  output logic                      hold_tag_tagged_out,
  output logic                      close_out,
  output logic [15:0]               user_logic_outputs_out
);

  localparam int TCW = $clog2(TICK_CYCLES);
  localparam logic [DLY_W-1:0] QUAL_LIMIT = DLY_W'(QUAL_TICKS);

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("ralf_top: TICK_CYCLES must be at least 2");
    end
    if (QUAL_TICKS >= (1 << DLY_W)) begin : g_bad_qual
      $error("ralf_top: QUAL_TICKS does not fit DLY_W");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Angle test: inside a sector of the given width centred on the setting
  function automatic logic in_sector(input logic [8:0] ang,
                                     input logic [8:0] centre);
    logic [9:0] diff;
    diff = 10'(ang) + 10'(`RALF_FULL_DEG) - 10'(centre);
    if (diff >= 10'(`RALF_FULL_DEG)) begin
      diff = diff - 10'(`RALF_FULL_DEG);
    end
    in_sector = (diff <= 10'(`RALF_SECTOR_DEG / 2)) ||
                (diff >= 10'(`RALF_FULL_DEG - `RALF_SECTOR_DEG / 2));
  endfunction : in_sector

  // Register state
  logic [1:0]       ctrl;
  logic [DLY_W-1:0] gov_delay;
  logic [8:0]       pdir_angle;
  logic [8:0]       gdir_angle;
  logic [TCW-1:0]   tick_count;
  logic             tick;
  logic             seal_clear;
  logic             set_prev;
  logic             reset_prev;
  logic             bus_req;
  logic             bus_take;
  logic             wr_take;
  logic             set_edge;
  logic             reset_edge;
  logic [31:0]      next_rdata;
  logic [2:0]       trip_flags;
  logic [2:0]       trip_latched;
  logic             var_timer_done;
  logic             watt_timer_done;
  logic             gov_timer_done;
  ralf_pkg::ralf_hht_state_t hht_state;
  ralf_pkg::ralf_hht_state_t next_hht_state;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then a one-cycle answer
  assign bus_req  = avs_read_in || avs_write_in;
  assign bus_take = bus_req && avs_waitrequest_out;
  assign wr_take  = avs_write_in && !avs_waitrequest_out;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !bus_take;
    end
  end

  // Read data, captured in the wait cycle and held for the answer
  always_comb begin
    next_rdata = `RALF_RDATA_RST;
    unique case (avs_address_in)
      `RALF_ADDR_CTRL:     next_rdata = 32'(ctrl);
      `RALF_ADDR_GOV_DLY:  next_rdata = 32'(gov_delay);
      `RALF_ADDR_USER:     next_rdata = 32'(user_logic_outputs_out);
      `RALF_ADDR_STATUS:   next_rdata = 32'({hold_tag_tagged_out,
                                             hold_tag_off_out,
                                             ground_overvolt_flag_out,
                                             pos_watt_alarm_one_out,
                                             cold_load_timing_flag_out,
                                             trip_flags,
                                             var_demand_flag_out,
                                             three_phase_undervolt_flag_out,
                                             neg_seq_zone_flag_out,
                                             pos_seq_zone_flag_out});
      `RALF_ADDR_LATCH:    next_rdata = 32'({trip_latched,
                                             three_phase_undervolt_latched_out});
      `RALF_ADDR_PDIR_ANG: next_rdata = 32'(pdir_angle);
      `RALF_ADDR_GDIR_ANG: next_rdata = 32'(gdir_angle);
      default:             next_rdata = `RALF_RDATA_RST;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= `RALF_RDATA_RST;
    end else if (bus_take && avs_read_in) begin
      avs_readdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable settings; unmapped and read-only offsets ignore writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl       <= `RALF_CTRL_RST;
      gov_delay  <= `RALF_GOV_DLY_RST;
      pdir_angle <= `RALF_ANG_RST;
      gdir_angle <= `RALF_ANG_RST;
      seal_clear <= 1'b0;
    end else begin
      seal_clear <= 1'b0;
      if (wr_take) begin
        unique case (avs_address_in)
          `RALF_ADDR_CTRL: begin
            ctrl       <= avs_writedata_in[1:0];
            seal_clear <= avs_writedata_in[`RALF_CTRL_SEAL_CLR];
          end
          `RALF_ADDR_GOV_DLY:  gov_delay  <= avs_writedata_in[DLY_W-1:0];
          `RALF_ADDR_PDIR_ANG: pdir_angle <= avs_writedata_in[8:0];
          `RALF_ADDR_GDIR_ANG: gdir_angle <= avs_writedata_in[8:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-second tick from the system clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == TCW'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Directional zone flags: sector test gated by element enable only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pos_seq_zone_flag_out <= 1'b0;
      neg_seq_zone_flag_out <= 1'b0;
    end else begin
      pos_seq_zone_flag_out <= ctrl[`RALF_CTRL_PDIR_EN] &&
                               in_sector(meas_in.pos_angle,
                                         pdir_angle);
      neg_seq_zone_flag_out <= ctrl[`RALF_CTRL_GDIR_EN] &&
                               in_sector(meas_in.neg_angle,
                                         gdir_angle);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Undervoltage, cold load and user outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      three_phase_undervolt_flag_out <= 1'b0;
      cold_load_timing_flag_out      <= 1'b0;
      user_logic_outputs_out         <= 16'h0000;
    end else begin
      three_phase_undervolt_flag_out <= &meas_in.uv_below;
      cold_load_timing_flag_out      <= meas_in.cold_load_run;
      user_logic_outputs_out         <= user_logic_eq_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualification timers for VAr demand, positive watts, ground overvolt
  ralf_qual_timer #(.CW(DLY_W)) u_var_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_in  (tick),
    .cond_in  (meas_in.var_dmd_over),
    .limit_in (QUAL_LIMIT),
    .flag_out (var_timer_done)
  );

  ralf_qual_timer #(.CW(DLY_W)) u_watt_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_in  (tick),
    .cond_in  (meas_in.watt1_over),
    .limit_in (QUAL_LIMIT),
    .flag_out (watt_timer_done)
  );

  ralf_qual_timer #(.CW(DLY_W)) u_gov_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_in  (tick),
    .cond_in  (meas_in.gnd_volt_over),
    .limit_in (gov_delay),
    .flag_out (gov_timer_done)
  );

  // Timer results registered onto the outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      var_demand_flag_out      <= 1'b0;
      pos_watt_alarm_one_out   <= 1'b0;
      ground_overvolt_flag_out <= 1'b0;
    end else begin
      var_demand_flag_out      <= var_timer_done;
      pos_watt_alarm_one_out   <= watt_timer_done;
      ground_overvolt_flag_out <= gov_timer_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase trip flags: set by a trip on that phase, set beats dropout
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trip_flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (meas_in.main_trip && meas_in.trip_phase[i]) begin
          trip_flags[i] <= 1'b1;
        end else if (meas_in.below_dropout[i]) begin
          trip_flags[i] <= 1'b0;
        end
      end
    end
  end

  assign trip_phase_a_flag_out = trip_flags[0];
  assign trip_phase_b_flag_out = trip_flags[1];
  assign trip_phase_c_flag_out = trip_flags[2];

  ////////////////////////////////////////////////////////////////////////////
  // Seal-in variants: set on base flag, cleared by command, set wins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      three_phase_undervolt_latched_out <= 1'b0;
      trip_latched                      <= 3'h0;
    end else begin
      if (three_phase_undervolt_flag_out) begin
        three_phase_undervolt_latched_out <= 1'b1;
      end else if (seal_clear) begin
        three_phase_undervolt_latched_out <= 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (trip_flags[i]) begin
          trip_latched[i] <= 1'b1;
        end else if (seal_clear) begin
          trip_latched[i] <= 1'b0;
        end
      end
    end
  end

  assign trip_phase_a_latched_out = trip_latched[0];
  assign trip_phase_b_latched_out = trip_latched[1];
  assign trip_phase_c_latched_out = trip_latched[2];

  ////////////////////////////////////////////////////////////////////////////
  // Hot hold tag: rising edges of set and reset move the state
  assign set_edge   = hold_tag_set_in && !set_prev;
  assign reset_edge = hold_tag_reset_in && !reset_prev;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      set_prev   <= 1'b0;
      reset_prev <= 1'b0;
    end else begin
      set_prev   <= hold_tag_set_in;
      reset_prev <= hold_tag_reset_in;
    end
  end

  always_comb begin
    next_hht_state = hht_state;
    unique case (hht_state)
      ralf_pkg::hht_on: begin
        if (set_edge) begin
          next_hht_state = ralf_pkg::hht_off;
        end
      end
      ralf_pkg::hht_off: begin
        if (set_edge) begin
          next_hht_state = ralf_pkg::hht_tag;
        end
      end
      ralf_pkg::hht_tag: begin
        if (reset_edge) begin
          next_hht_state = ralf_pkg::hht_off;
        end
      end
      default: next_hht_state = ralf_pkg::hht_on;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hht_state           <= ralf_pkg::hht_on;
      hold_tag_off_out    <= 1'b0;
      hold_tag_tagged_out <= 1'b0;
    end else begin
      hht_state           <= next_hht_state;
      hold_tag_off_out    <= (next_hht_state == ralf_pkg::hht_off);
      hold_tag_tagged_out <= (next_hht_state == ralf_pkg::hht_tag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Close gating by tag state; the OFF output is left for the user to route
  // into reclose blocking as well
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      close_out <= 1'b0;
    end else begin
      unique case (hht_state)
        ralf_pkg::hht_on:  close_out <= |close_req_in;
        ralf_pkg::hht_off: close_out <= close_req_in.manual_local;
        ralf_pkg::hht_tag: close_out <= 1'b0;
        default:           close_out <= 1'b0;
      endcase
    end
  end

endmodule : ralf_top

// ### ralf_top_assertions.sv
// Checker for the relay alarm flag logic, bound to the top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module ralf_top_assertions #(
  parameter int TICK_CYCLES = 10,
  parameter int QUAL_TICKS  = 3,
  parameter int DLY_W       = 8
) (
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire ralf_pkg::ralf_meas_t  meas_in,
  input wire ralf_pkg::ralf_close_t close_req_in,
  input wire logic                  hold_tag_set_in,
  input wire logic                  hold_tag_reset_in,
  input wire logic [15:0]           user_logic_eq_in,
  input wire logic                  three_phase_undervolt_flag_out,
  input wire logic                  var_demand_flag_out,
  input wire logic                  trip_phase_a_flag_out,
  input wire logic                  cold_load_timing_flag_out,
  input wire logic                  pos_watt_alarm_one_out,
  input wire logic                  hold_tag_off_out,
  input wire logic                  hold_tag_tagged_out,
  input wire logic                  close_out,
  input wire logic [15:0]           user_logic_outputs_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  int var_run;
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles the VAr condition has held
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !meas_in.var_dmd_over) begin
      var_run <= 0;
    end else begin
      var_run <= var_run + 1;
    end
  end
  // Steps of the trip and tag behaviour
  sequence trip_a_seen;
    meas_in.main_trip && meas_in.trip_phase[0];
  endsequence
  sequence tag_held;
    hold_tag_tagged_out ##1 hold_tag_tagged_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_uv_needs_all: assert property (!(&meas_in.uv_below) |=> !three_phase_undervolt_flag_out)
    else $error("undervolt flag wrong");
  a_cold_follow: assert property (meas_in.cold_load_run |=> cold_load_timing_flag_out)
    else $error("cold load flag low");
  a_trip_a_set: assert property (trip_a_seen |=> trip_phase_a_flag_out)
    else $error("trip A not set");
  a_tag_blocks_close: assert property (tag_held |-> !close_out)
    else $error("close while tagged");
  a_off_local_only: assert property (hold_tag_off_out ##1
    (hold_tag_off_out && !$past(close_req_in.manual_local)) |-> !close_out)
    else $error("close in off state");
  a_tag_from_off: assert property ($rose(hold_tag_tagged_out) |->
    $past(hold_tag_off_out) && $past(hold_tag_set_in))
    else $error("bad tag entry");
  a_off_entry: assert property ($rose(hold_tag_off_out) |->
    ($past(hold_tag_set_in) && !$past(hold_tag_tagged_out)) ||
    ($past(hold_tag_reset_in) && $past(hold_tag_tagged_out)))
    else $error("bad off entry");
  a_user_delay: assert property (1'b1 |=> user_logic_outputs_out == $past(user_logic_eq_in))
    else $error("user outputs wrong");
  a_var_not_early: assert property ($rose(var_demand_flag_out) |->
    var_run >= (QUAL_TICKS - 1) * TICK_CYCLES)
    else $error("var flag early");
  a_watt_clear: assert property (!meas_in.watt1_over |-> ##2 !pos_watt_alarm_one_out)
    else $error("watt alarm stuck");
endmodule : ralf_top_assertions
bind ralf_top ralf_top_assertions #(.TICK_CYCLES(TICK_CYCLES), .QUAL_TICKS(QUAL_TICKS),
  .DLY_W(DLY_W)) ralf_top_assertions_i (.*);

// ### testbench.sv
// Self-checking bench for the relay alarm flag logic.
// Assumes the far model and checker compile first.
`timescale 1ns/1ns
module testbench;
  localparam int T = 10;
  localparam int Q = 3;
  logic                  clk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic [7:0]            avs_address_in = 8'h00;
  logic                  avs_read_in = 1'b0;
  logic                  avs_write_in = 1'b0;
  logic [31:0]           avs_writedata_in = 32'h0000_0000;
  logic [31:0]           avs_readdata_out, ctl, pc, gc, rd;
  logic [31:0]           rs = 32'h0000_0040;
  logic                  avs_waitrequest_out, hold_tag_set_in, hold_tag_reset_in, close_out;
  ralf_pkg::ralf_meas_t  meas_in;
  ralf_pkg::ralf_close_t close_req_in;
  logic [15:0]           user_logic_eq_in, user_logic_outputs_out, e_usr;
  logic                  pos_seq_zone_flag_out, neg_seq_zone_flag_out, var_demand_flag_out;
  logic                  three_phase_undervolt_flag_out, three_phase_undervolt_latched_out;
  logic                  trip_phase_a_flag_out, trip_phase_b_flag_out, trip_phase_c_flag_out;
  logic                  trip_phase_a_latched_out, trip_phase_b_latched_out;
  logic                  trip_phase_c_latched_out, cold_load_timing_flag_out;
  logic                  pos_watt_alarm_one_out, ground_overvolt_flag_out;
  logic                  hold_tag_off_out, hold_tag_tagged_out;
  logic [2:0]            e_tr, e_trl, tfl;
  logic                  e_pos, e_neg, e_uv, e_uvl, e_cold, e_cls, ps, pr, clr;
  logic                  go = 1'b0;
  logic [28:0]           ev, dv;
  logic [7:0]            ra [4] = '{8'h00, 8'h04, 8'h14, 8'h1C};
  logic [31:0]           rv [4] = '{32'h0000_0003, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
  bit                    tg [5] = '{1, 1, 1, 0, 0};
  int                    st, failures, check_count, cyc;
  ////////////////////////////////////////////////////////////////////////////////
  ralf_far_model far_i (.clk_in, .off_in(hold_tag_off_out), .meas_out(meas_in),
    .close_out(close_req_in), .set_out(hold_tag_set_in), .reset_out(hold_tag_reset_in),
    .user_out(user_logic_eq_in));
  ralf_top #(.TICK_CYCLES(T), .QUAL_TICKS(Q), .DLY_W(8)) ralf_top_i (.*);
  // Design flags in model vector order
  assign tfl = {ground_overvolt_flag_out, pos_watt_alarm_one_out, var_demand_flag_out};
  assign dv = {pos_seq_zone_flag_out, neg_seq_zone_flag_out, three_phase_undervolt_flag_out,
    three_phase_undervolt_latched_out, cold_load_timing_flag_out, trip_phase_c_flag_out,
    trip_phase_b_flag_out, trip_phase_a_flag_out, trip_phase_c_latched_out,
    trip_phase_b_latched_out, trip_phase_a_latched_out, hold_tag_off_out,
    hold_tag_tagged_out, user_logic_outputs_out};
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  function automatic logic zone(input logic [8:0] a, input logic [31:0] c);
    int d = (int'(a) - int'(c) + 360) % 360;
    return d <= 90 || d >= 270;
  endfunction : zone
  task automatic chk(input string nm, input logic [31:0] ex, got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // Avalon-MM access held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    {avs_write_in, avs_read_in} <= {wr, !wr};
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
  endtask : bus
  task automatic rand_run(input int n);
    repeat (n) begin
      @(negedge clk_in);
      far_i.m.pos_angle = 9'(xs() % 360);
      far_i.m.neg_angle = 9'(xs() % 360);
      {far_i.m.uv_below, far_i.m.main_trip, far_i.m.trip_phase, far_i.m.below_dropout,
       far_i.m.cold_load_run} = 11'(xs());
      far_i.u = 16'(xs());
      far_i.req = 3'(xs());
    end
  endtask : rand_run
  task automatic setc(input int k, input logic v);
    {far_i.m.gnd_volt_over, far_i.m.watt1_over, far_i.m.var_dmd_over} = 3'(v) << k;
  endtask : setc
  // Timed alarm: a short run, when pre > 0, must not qualify, then a full one
  task automatic qual(input int k, input int lim, input int pre);
    int n = 0;
    if (pre > 0) begin
      setc(k, 1'b1);
      repeat (pre) @(negedge clk_in);
      setc(k, 1'b0);
      repeat (2) @(negedge clk_in);
      chk("early flag", 0, tfl[k]);
    end
    setc(k, 1'b1);
    while (tfl[k] !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    chk("qual time", 1, n >= (lim - 1) * T && n <= lim * T + 4);
    setc(k, 1'b0);
    repeat (4) @(negedge clk_in);
    chk("flag drop", 0, tfl[k]);
  endtask : qual
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // Cycle model of flags, tag state and close
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 6000) begin
      failures++;
      results();
    end
    if (!rst_n_in) begin
      {e_tr, e_trl, e_pos, e_neg, e_uv, e_uvl, e_cold, e_cls, ps, pr, e_usr, pc, gc, clr} = 0;
      st = 0;
      ctl = 32'h0000_0003;
    end else begin
      {e_trl, e_uvl} = (clr ? 4'h0 : {e_trl, e_uvl}) | {e_tr, e_uv};
      clr = avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00
            && avs_writedata_in[2];
      e_cls = st == 0 ? |close_req_in : st == 1 && close_req_in.manual_local;
      if (hold_tag_set_in && !ps) st = st == 0 ? 1 : 2;
      if (hold_tag_reset_in && !pr && st == 2) st = 1;
      ps = hold_tag_set_in;
      pr = hold_tag_reset_in;
      e_pos = ctl[0] && zone(meas_in.pos_angle, pc);
      e_neg = ctl[1] && zone(meas_in.neg_angle, gc);
      e_uv = &meas_in.uv_below;
      e_cold = meas_in.cold_load_run;
      e_tr = ({3{meas_in.main_trip}} & meas_in.trip_phase) | (e_tr & ~meas_in.below_dropout);
      e_usr = user_logic_eq_in;
      if (avs_write_in && !avs_waitrequest_out) begin
        case (avs_address_in)
          8'h00: ctl = avs_writedata_in;
          8'h14: pc = avs_writedata_in;
          8'h18: gc = avs_writedata_in;
          default: ;
        endcase
      end
    end
    ev = {e_pos, e_neg, e_uv, e_uvl, e_cold, e_tr, e_trl, st == 1, st == 2, e_usr};
  end
  // Compare at each falling edge
  always @(negedge clk_in) begin
    if (go) begin
      chk("flags", ev, dv);
      chk("close", e_cls, close_out);
    end
  end
  // Main sequence
  initial begin
    @(posedge clk_in);
    go = 1'b1;
    repeat (11) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0000_0000, rd);
      chk("register", rv[i], rd);
    end
    rand_run(80);
    bus(1'b1, 8'h14, 32'h0000_0064, rd);
    bus(1'b1, 8'h18, 32'h0000_012C, rd);
    rand_run(80);
    bus(1'b1, 8'h00, 32'h0000_0000, rd);
    rand_run(40);
    far_i.m = '0;
    far_i.m.below_dropout = 3'h7;
    bus(1'b1, 8'h00, 32'h0000_0007, rd);
    bus(1'b0, 8'h10, 32'h0000_0000, rd);
    chk("latch", 32'h0000_0000, rd);
    qual(0, Q, 0);
    qual(1, Q, (Q - 1) * T - 4);
    bus(1'b1, 8'h04, 32'h0000_0004, rd);
    qual(2, 4, 0);
    foreach (tg[i]) begin
      {far_i.s, far_i.r} = {tg[i], !tg[i]};
      rand_run(4);
      {far_i.s, far_i.r} = 2'b00;
      rand_run(4);
    end
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rand_run(20);
    results();
  end
endmodule : testbench
